// file: cpl_map.vh
// Purpose: constants for the cache partition label tracking block
// Assumes: included by bare name from the design files
// Notes: event and downstream encodings, default geometry and options
//
// What this block does
// R1: requesters without native labels get labels from some system mechanism.
// R2: such requesters may tie identifier and group to defaults.
// R3: the interconnect carries every label field through to the target.
// R4: one settings table per control, indexed by identifier and security flag.
// R5: the indexed setting goes to the regulator that governs allocation.
// R6: per-partition usage is measured and compared with the setting.
// R7: labelling runs beside the normal request path, never altering it.
// R8: way partitioning needs no measurement, only a permitted way mask.
// R9: an allocating request's full label is kept with the line.
// R10: a miss fill downstream carries the incoming request's label.
// R11: request label selects settings and drives usage accounting.
// R12: upstream events filter on request label, internal ones on stored label.
// R13: an eviction to another cache carries the line's stored label.
// R14: last-level eviction to memory may use request or stored label.
// R15: a write hit with a different label may relabel the line.
// R16: relabelling alone never moves the line.
// R17: relocation only when identifier changed and portion not permitted.
// R18: a portion may be one entry or a group of entries.
// R19: portion and maximum-capacity limits may apply together.
// R20: the storage monitor reports lines held by the monitored partition.
// R21: every request carries identifier, monitor group and security flag.
// R22: a buffered request keeps its label until serviced or forwarded.
// R23: one address may live under several identifiers; labels are per line.
// R24: invalidated lines leave the usage count in the same cycle.
// R25: each optional behaviour is a static parameter.
`ifndef CPL_MAP_VH
`define CPL_MAP_VH

// event kinds from the cache pipeline
`define EVT_LOOKUP 3'h0
`define EVT_ALLOC 3'h1
`define EVT_WRHIT 3'h2
`define EVT_EVICT 3'h3
`define EVT_CLEAN 3'h4
`define EVT_INVAL 3'h5

// downstream request kinds
`define DN_FILL 2'h0
`define DN_EVICT 2'h1
`define DN_CLEAN 2'h2

// default geometry and option values
`define DEF_SET_W 4
`define DEF_WAY_W 2
`define DEF_PID_W 4
`define DEF_GRP_W 1
`define DEF_RELABEL 1
`define DEF_RELOCATE 1
`define DEF_LAST_LEVEL 0
`define DEF_LL_REQ_LABEL 0

`endif

// file: label_store.v
// Purpose: per-line label storage with registered read data
// Assumes: one write and one read port on the same clock
// Notes: read of a line written in the same cycle returns the old value
`timescale 1ns/1ps
`default_nettype none

module label_store #(
	parameter AW = 6,
	parameter DW = 6
) (
	// clock
	input wire clock,
	// write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	// read port
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// contents need no reset: valid bits live outside
	always @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // label_store

`default_nettype wire

// file: cache_label_track.v
// Purpose: partition label tracking beside a cache pipeline
// Assumes: one event per cycle; labels arrive complete with each event
// Notes: two-stage: capture and label read, then act on stored label
`timescale 1ns/1ps
`include "cpl_map.vh"
`default_nettype none

module cache_label_track #(
	parameter SET_W = `DEF_SET_W,
	parameter WAY_W = `DEF_WAY_W,
	parameter PID_W = `DEF_PID_W,
	parameter GRP_W = `DEF_GRP_W,
	parameter RELABEL_ON_WRITE = `DEF_RELABEL, // R25
	parameter RELOCATE_ON_WRITE = `DEF_RELOCATE, // R25
	parameter IS_LAST_LEVEL = `DEF_LAST_LEVEL, // R25
	parameter LL_EVICT_REQ_LABEL = `DEF_LL_REQ_LABEL // R25
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// events from the cache pipeline, with request label
	input wire evt_valid,
	input wire [2:0] evt_kind,
	input wire [SET_W+WAY_W-1:0] evt_line,
	input wire [PID_W-1:0] evt_partition_id,
	input wire [GRP_W-1:0] evt_monitor_group,
	input wire evt_security_space_flag,
	// settings table write
	input wire cfg_we,
	input wire [PID_W:0] cfg_index,
	input wire [(1<<WAY_W)-1:0] cfg_portion_bitmap,
	input wire [SET_W+WAY_W:0] cfg_max_lines,
	// monitor selection
	input wire [PID_W-1:0] mon_partition_id,
	input wire mon_security_space_flag,
	input wire [GRP_W-1:0] mon_monitor_group,
	input wire mon_group_match,
	// regulator answer
	output reg alloc_valid_q,
	output reg [(1<<WAY_W)-1:0] alloc_way_mask_q,
	output reg over_capacity_q,
	// downstream request label
	output reg down_valid_q,
	output reg [1:0] down_kind_q,
	output reg [SET_W+WAY_W-1:0] down_line_q,
	output reg [PID_W-1:0] down_partition_id_q,
	output reg [GRP_W-1:0] down_monitor_group_q,
	output reg down_security_space_flag_q,
	// relocation request
	output reg relocate_q,
	output reg [SET_W+WAY_W-1:0] relocate_line_q,
	// monitoring
	output reg [SET_W+WAY_W:0] mon_storage_q,
	output reg mon_event_q
);
	localparam LINE_W = SET_W + WAY_W;
	localparam WAYS = 1 << WAY_W;
	localparam LINES = 1 << LINE_W;
	localparam IDX_W = PID_W + 1;
	localparam NPART = 1 << IDX_W;
	localparam CNT_W = LINE_W + 1;
	localparam LBL_W = PID_W + GRP_W + 1;
	localparam [CNT_W-1:0] CAP_RESET = {1'b1, {LINE_W{1'b0}}};

	// label layout {flag, group, identifier}
	function [IDX_W-1:0] label_index;
		input [LBL_W-1:0] lbl;
		begin
			label_index = {lbl[LBL_W-1], lbl[PID_W-1:0]};
		end
	endfunction

	function mon_hit;
		input [LBL_W-1:0] lbl;
		input [PID_W-1:0] pid;
		input ns;
		input [GRP_W-1:0] grp;
		input use_grp;
		begin
			mon_hit = (lbl[PID_W-1:0] == pid) && (lbl[LBL_W-1] == ns) &&
				(!use_grp || lbl[LBL_W-2:PID_W] == grp);
		end
	endfunction

	// stage one: captured event, label held unchanged
	reg s_valid_q;
	reg [2:0] s_kind_q;
	reg [LINE_W-1:0] s_line_q;
	reg [LBL_W-1:0] s_lbl_q;
	reg byp_valid_q;
	reg [LBL_W-1:0] byp_data_q;
	reg [LINES-1:0] line_valid_q;
	reg [WAYS-1:0] bitmap_q [0:NPART-1];
	reg [CNT_W-1:0] cap_q [0:NPART-1];
	wire [LBL_W-1:0] rd_label;
	wire [NPART*CNT_W-1:0] cnt_flat;
	integer i;

	// stage one decisions
	reg mem_we;
	reg [LBL_W-1:0] mem_wdata;
	reg set_valid;
	reg clr_valid;
	reg inc_en;
	reg dec_en;
	reg dn_en;
	reg [1:0] dn_kind;
	reg [LBL_W-1:0] dn_lbl;
	reg reloc;
	reg mon_evt;
	reg [LBL_W-1:0] stored;
	reg [IDX_W-1:0] idx_req;
	reg [IDX_W-1:0] idx_old;
	reg [CNT_W-1:0] used_req;
	reg line_v;
	reg over_cap;
	reg lbl_sel_req;

	label_store #(
		.AW(LINE_W),
		.DW(LBL_W)
	) u_store (
		.clock(clock),
		.we(mem_we),
		.waddr(s_line_q),
		.wdata(mem_wdata),
		.raddr(evt_line),
		.rdata(rd_label)
	);

	// event capture; label rides with the event untouched
	always @(posedge clock) begin
		if (rst) begin
			s_valid_q <= 1'b0;
			s_kind_q <= 3'h0;
			s_line_q <= {LINE_W{1'b0}};
			s_lbl_q <= {LBL_W{1'b0}};
			byp_valid_q <= 1'b0;
			byp_data_q <= {LBL_W{1'b0}};
		end else begin
			s_valid_q <= evt_valid; // R7
			s_kind_q <= evt_kind;
			s_line_q <= evt_line;
			s_lbl_q <= {evt_security_space_flag, evt_monitor_group,
				evt_partition_id}; // R21 R22
			// a write to the line now being read would be missed
			byp_valid_q <= mem_we && (s_line_q == evt_line);
			byp_data_q <= mem_wdata;
		end
	end

	// settings table: bitmap and capacity per identifier and flag
	always @(posedge clock) begin
		if (rst) begin
			for (i = 0; i < NPART; i = i + 1) begin
				bitmap_q[i] <= {WAYS{1'b1}};
				cap_q[i] <= CAP_RESET;
			end
		end else if (cfg_we) begin
			bitmap_q[cfg_index] <= cfg_portion_bitmap; // R4
			cap_q[cfg_index] <= cfg_max_lines; // R4
		end
	end

	// decide the effect of the captured event
	always @* begin
		stored = byp_valid_q ? byp_data_q : rd_label;
		idx_req = label_index(s_lbl_q); // R11
		idx_old = label_index(stored);
		used_req = cnt_flat[idx_req*CNT_W +: CNT_W];
		line_v = line_valid_q[s_line_q];
		over_cap = used_req >= cap_q[idx_req]; // R6
		lbl_sel_req = (IS_LAST_LEVEL != 0) && (LL_EVICT_REQ_LABEL != 0);
		mem_we = 1'b0;
		mem_wdata = s_lbl_q;
		set_valid = 1'b0;
		clr_valid = 1'b0;
		inc_en = 1'b0;
		dec_en = 1'b0;
		dn_en = 1'b0;
		dn_kind = `DN_FILL;
		dn_lbl = s_lbl_q;
		reloc = 1'b0;
		mon_evt = 1'b0;
		if (s_valid_q) begin
			case (s_kind_q)
			`EVT_LOOKUP: begin
				mon_evt = mon_hit(s_lbl_q, mon_partition_id,
					mon_security_space_flag, mon_monitor_group,
					mon_group_match); // R12
			end
			`EVT_ALLOC: begin
				mem_we = 1'b1; // R9 R23
				set_valid = 1'b1;
				inc_en = 1'b1; // R11
				dec_en = line_v;
				dn_en = 1'b1; // R10
				dn_kind = `DN_FILL;
				dn_lbl = s_lbl_q; // R10
				mon_evt = mon_hit(s_lbl_q, mon_partition_id,
					mon_security_space_flag, mon_monitor_group,
					mon_group_match); // R12
			end
			`EVT_WRHIT: begin
				mon_evt = mon_hit(s_lbl_q, mon_partition_id,
					mon_security_space_flag, mon_monitor_group,
					mon_group_match); // R12
				if ((RELABEL_ON_WRITE != 0) && line_v &&
					(stored != s_lbl_q)) begin
					mem_we = 1'b1; // R15 R16
					inc_en = 1'b1;
					dec_en = 1'b1;
					// only a request to the cache; the line stays put here
					reloc = (RELOCATE_ON_WRITE != 0) &&
						(stored[PID_W-1:0] != s_lbl_q[PID_W-1:0]) &&
						!bitmap_q[idx_req][s_line_q[WAY_W-1:0]]; // R17
				end
			end
			`EVT_EVICT: begin
				if (line_v) begin
					clr_valid = 1'b1;
					dec_en = 1'b1; // R24
					dn_en = 1'b1;
					dn_kind = `DN_EVICT;
					dn_lbl = lbl_sel_req ? s_lbl_q : stored; // R13 R14
					mon_evt = mon_hit(stored, mon_partition_id,
						mon_security_space_flag, mon_monitor_group,
						mon_group_match); // R12
				end
			end
			`EVT_CLEAN: begin
				if (line_v) begin
					dn_en = 1'b1;
					dn_kind = `DN_CLEAN;
					dn_lbl = lbl_sel_req ? s_lbl_q : stored; // R13 R14
					mon_evt = mon_hit(stored, mon_partition_id,
						mon_security_space_flag, mon_monitor_group,
						mon_group_match); // R12
				end
			end
			`EVT_INVAL: begin
				clr_valid = line_v;
				dec_en = line_v; // R24
			end
			default: begin
				mon_evt = 1'b0;
			end
			endcase
		end
	end

	// valid bit per line, cleared with the count drop
	always @(posedge clock) begin
		if (rst) begin
			line_valid_q <= {LINES{1'b0}};
		end else if (set_valid) begin
			line_valid_q[s_line_q] <= 1'b1;
		end else if (clr_valid) begin
			line_valid_q[s_line_q] <= 1'b0; // R24
		end
	end

	// usage counter per partition; inc and dec may hit the same one
	genvar g;
	generate
		for (g = 0; g < NPART; g = g + 1) begin : g_cnt
			reg [CNT_W-1:0] cnt_q;
			wire up = inc_en && (idx_req == g);
			wire dn = dec_en && (idx_old == g);
			always @(posedge clock) begin
				if (rst) begin
					cnt_q <= {CNT_W{1'b0}};
				end else if (up && !dn) begin
					cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // R6
				end else if (dn && !up) begin
					cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // R24
				end
			end
			assign cnt_flat[g*CNT_W +: CNT_W] = cnt_q;
		end
	endgenerate

	// regulator: permitted ways, emptied once capacity is reached
	always @(posedge clock) begin
		if (rst) begin
			alloc_valid_q <= 1'b0;
			alloc_way_mask_q <= {WAYS{1'b0}};
			over_capacity_q <= 1'b0;
		end else begin
			alloc_valid_q <= s_valid_q && (s_kind_q == `EVT_LOOKUP);
			// a way is a portion; one-way caches make entries the portion
			alloc_way_mask_q <= over_cap ? {WAYS{1'b0}} :
				bitmap_q[idx_req]; // R5 R8 R18 R19
			over_capacity_q <= over_cap; // R6
		end
	end

	// downstream label, relocation and monitor outputs
	always @(posedge clock) begin
		if (rst) begin
			down_valid_q <= 1'b0;
			down_kind_q <= `DN_FILL;
			down_line_q <= {LINE_W{1'b0}};
			down_partition_id_q <= {PID_W{1'b0}};
			down_monitor_group_q <= {GRP_W{1'b0}};
			down_security_space_flag_q <= 1'b0;
			relocate_q <= 1'b0;
			relocate_line_q <= {LINE_W{1'b0}};
			mon_storage_q <= {CNT_W{1'b0}};
			mon_event_q <= 1'b0;
		end else begin
			down_valid_q <= dn_en;
			down_kind_q <= dn_kind;
			down_line_q <= s_line_q;
			down_partition_id_q <= dn_lbl[PID_W-1:0]; // R21
			down_monitor_group_q <= dn_lbl[LBL_W-2:PID_W];
			down_security_space_flag_q <= dn_lbl[LBL_W-1];
			relocate_q <= reloc; // R17
			relocate_line_q <= s_line_q;
			mon_storage_q <= cnt_flat[{mon_security_space_flag,
				mon_partition_id}*CNT_W +: CNT_W]; // R20
			mon_event_q <= mon_evt; // R12
		end
	end
endmodule // cache_label_track

`default_nettype wire

// file: cache_label_track_properties.sv
// Purpose: port timing checks for the label tracker
// Assumes: answers appear two edges after the event is taken
// Notes: bound to every cache_label_track instance
`timescale 1ns/1ps
`include "cpl_map.vh"
`default_nettype none
module label_track_checker #(
	parameter SET_W = 4,
	parameter WAY_W = 2,
	parameter PID_W = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// events
	input wire logic evt_valid,
	input wire logic [2:0] evt_kind,
	input wire logic [SET_W+WAY_W-1:0] evt_line,
	input wire logic [PID_W-1:0] evt_partition_id,
	// answers
	input wire logic alloc_valid_q,
	input wire logic [(1<<WAY_W)-1:0] alloc_way_mask_q,
	input wire logic over_capacity_q,
	input wire logic down_valid_q,
	input wire logic [1:0] down_kind_q,
	input wire logic [SET_W+WAY_W-1:0] down_line_q,
	input wire logic [PID_W-1:0] down_partition_id_q,
	input wire logic relocate_q,
	input wire logic [SET_W+WAY_W-1:0] relocate_line_q,
	input wire logic mon_event_q
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// event kinds entering the pipe
	sequence fill_in; evt_valid && evt_kind == `EVT_ALLOC; endsequence
	sequence look_in; evt_valid && evt_kind == `EVT_LOOKUP; endsequence
	sequence drop_in; evt_valid && evt_kind == `EVT_INVAL; endsequence
	// output pulses are only ever caused by an event two edges back; masks and counts follow state
	sequence fill_out; down_valid_q && down_kind_q == `DN_FILL; endsequence
	fill_label_a: assert property (fill_in |-> ##2 fill_out
		##0 (down_line_q == $past(evt_line, 2))
		##0 (down_partition_id_q == $past(evt_partition_id, 2)))
		else $error("fill label wrong");
	lookup_answer_a: assert property (look_in |-> ##2 alloc_valid_q)
		else $error("lookup not answered");
	answer_cause_a: assert property (alloc_valid_q |->
		$past(evt_valid, 2) && $past(evt_kind, 2) == `EVT_LOOKUP)
		else $error("answer without lookup");
	full_mask_a: assert property (alloc_valid_q && over_capacity_q
		|-> alloc_way_mask_q == 0) else $error("mask while full");
	down_cause_a: assert property (down_valid_q |-> $past(evt_valid, 2)
		&& down_line_q == $past(evt_line, 2)) else $error("stray request");
	evict_kind_a: assert property (down_valid_q
		&& $past(evt_kind, 2) == `EVT_EVICT |-> down_kind_q == `DN_EVICT)
		else $error("evict kind wrong");
	move_cause_a: assert property (relocate_q |->
		$past(evt_kind, 2) == `EVT_WRHIT
		&& relocate_line_q == $past(evt_line, 2))
		else $error("stray relocation");
	drop_quiet_a: assert property (drop_in |-> ##2
		!(down_valid_q || alloc_valid_q || relocate_q || mon_event_q))
		else $error("invalidate made output");
	mon_cause_a: assert property (mon_event_q |-> $past(evt_valid, 2)
		&& $past(evt_kind, 2) != `EVT_INVAL) else $error("stray event");
endmodule // label_track_checker
bind cache_label_track label_track_checker #(.SET_W(SET_W),
	.WAY_W(WAY_W), .PID_W(PID_W)) props (.clock, .rst, .evt_valid,
	.evt_kind, .evt_line, .evt_partition_id, .alloc_valid_q,
	.alloc_way_mask_q, .over_capacity_q, .down_valid_q, .down_kind_q,
	.down_line_q, .down_partition_id_q, .relocate_q, .relocate_line_q,
	.mon_event_q);
`default_nettype wire

// file: down_sink.sv
// Purpose: downstream cache stand-in tallying requests
// Assumes: requests are one-cycle pulses
// Notes: no back-pressure exists, so every pulse is taken
`timescale 1ns/1ps
`default_nettype none
module down_sink (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// request from the tracker
	input wire logic down_valid_q,
	input wire logic [1:0] down_kind_q,
	// tallies
	output var logic [7:0] n_fill,
	output var logic [7:0] n_evict
);
	// count fills and evictions; a lost one shows up as a short tally
	always @(posedge clock) begin
		if (rst) begin
			n_fill <= 8'h00;
			n_evict <= 8'h00;
		end else if (down_valid_q) begin
			n_fill <= n_fill + {7'h00, down_kind_q == 2'h0};
			n_evict <= n_evict + {7'h00, down_kind_q == 2'h1};
		end
	end
endmodule // down_sink
`default_nettype wire

// file: cache_label_track_bench.sv
// Purpose: directed tests of the label tracker
// Assumes: default parameters; monitor watches id 3, flag 0
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "cpl_map.vh"
`default_nettype none
module cache_label_track_bench;
	logic clock, rst, evt_valid, evt_security_space_flag, cfg_we;
	logic [2:0] evt_kind;
	logic [5:0] evt_line, down_line_q, relocate_line_q;
	logic [3:0] evt_partition_id, cfg_portion_bitmap, mon_partition_id;
	logic [3:0] alloc_way_mask_q, down_partition_id_q;
	logic [0:0] evt_monitor_group, mon_monitor_group, down_monitor_group_q;
	logic [4:0] cfg_index;
	logic [6:0] cfg_max_lines, mon_storage_q;
	logic mon_security_space_flag, mon_group_match, alloc_valid_q;
	logic over_capacity_q, down_valid_q, relocate_q, mon_event_q;
	logic down_security_space_flag_q;
	logic [1:0] down_kind_q;
	logic [7:0] n_fill, n_evict;
	int n_fail, n_tests;
	wire [13:0] dn = {down_kind_q, down_line_q, down_partition_id_q,
		down_monitor_group_q, down_security_space_flag_q};
	wire [5:0] ans = {alloc_valid_q, over_capacity_q, alloc_way_mask_q};

	cache_label_track dut (.clock, .rst, .evt_valid, .evt_kind, .evt_line,
		.evt_partition_id, .evt_monitor_group, .evt_security_space_flag,
		.cfg_we, .cfg_index, .cfg_portion_bitmap, .cfg_max_lines,
		.mon_partition_id, .mon_security_space_flag, .mon_monitor_group,
		.mon_group_match, .alloc_valid_q, .alloc_way_mask_q,
		.over_capacity_q, .down_valid_q, .down_kind_q, .down_line_q,
		.down_partition_id_q, .down_monitor_group_q,
		.down_security_space_flag_q, .relocate_q, .relocate_line_q,
		.mon_storage_q, .mon_event_q);
	down_sink sink (.clock, .rst, .down_valid_q, .down_kind_q, .n_fill,
		.n_evict);

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task tick;
		@(posedge clock);
		#1;
	endtask
	// one event, then wait until its answer stands
	task ev(input logic [2:0] k, input logic [5:0] l,
		input logic [3:0] p, input logic g, input logic s);
		evt_valid = 1'h1;
		evt_kind = k;
		evt_line = l;
		{evt_partition_id, evt_monitor_group, evt_security_space_flag} =
			{p, g, s};
		tick;
		evt_valid = 1'h0;
		tick;
	endtask
	task cfg(input logic [4:0] i, input logic [3:0] b, input logic [6:0] m);
		cfg_we = 1'h1;
		{cfg_index, cfg_portion_bitmap, cfg_max_lines} = {i, b, m};
		tick;
		cfg_we = 1'h0;
	endtask
	task t_fill_evict;
		ev(`EVT_ALLOC, 6'h05, 4'h3, 1'h1, 1'h0);
		chk(dn, {2'h0, 6'h05, 4'h3, 1'h1, 1'h0});
		chk(mon_event_q, 1'h1);
		tick;
		chk(mon_storage_q, 7'h01);
		ev(`EVT_EVICT, 6'h05, 4'h9, 1'h0, 1'h1);
		chk({down_valid_q, dn}, {1'h1, 2'h1, 6'h05, 4'h3, 1'h1, 1'h0});
		chk(mon_event_q, 1'h1);
		tick;
		chk(mon_storage_q, 7'h00);
		ev(`EVT_EVICT, 6'h05, 4'h3, 1'h1, 1'h0);
		chk(down_valid_q, 1'h0);
		$display("test fill_evict done");
	endtask
	task t_clean_inval;
		ev(`EVT_ALLOC, 6'h0A, 4'h3, 1'h0, 1'h1);
		ev(`EVT_CLEAN, 6'h0A, 4'h3, 1'h0, 1'h0);
		chk({down_valid_q, dn}, {1'h1, 2'h2, 6'h0A, 4'h3, 1'h0, 1'h1});
		chk(mon_event_q, 1'h0);
		ev(`EVT_ALLOC, 6'h0C, 4'h3, 1'h0, 1'h0);
		tick;
		chk(mon_storage_q, 7'h01);
		ev(`EVT_INVAL, 6'h0C, 4'h3, 1'h0, 1'h0);
		chk(down_valid_q, 1'h0);
		tick;
		chk(mon_storage_q, 7'h00);
		$display("test clean_inval done");
	endtask
	task t_lookup;
		cfg(5'h03, 4'h6, 7'h01);
		ev(`EVT_ALLOC, 6'h09, 4'h3, 1'h0, 1'h0);
		ev(`EVT_LOOKUP, 6'h00, 4'h3, 1'h0, 1'h0);
		chk(ans, 6'h30);
		ev(`EVT_LOOKUP, 6'h00, 4'h3, 1'h0, 1'h1);
		chk(ans, 6'h2F);
		cfg(5'h03, 4'h6, 7'h40);
		ev(`EVT_LOOKUP, 6'h00, 4'h3, 1'h0, 1'h0);
		chk(ans, 6'h26);
		$display("test lookup done");
	endtask
	task t_relabel;
		cfg(5'h05, 4'h5, 7'h40);
		ev(`EVT_WRHIT, 6'h09, 4'h5, 1'h0, 1'h0);
		chk({relocate_q, relocate_line_q}, 7'h49);
		ev(`EVT_WRHIT, 6'h09, 4'h5, 1'h1, 1'h0);
		chk(relocate_q, 1'h0);
		ev(`EVT_EVICT, 6'h09, 4'h3, 1'h0, 1'h0);
		chk({down_valid_q, dn}, {1'h1, 2'h1, 6'h09, 4'h5, 1'h1, 1'h0});
		// the sink tallies the pulse at the edge after it stands
		tick;
		chk({n_fill, n_evict}, 16'h0402);
		$display("test relabel done");
	endtask
	// alloc then evict of one line in consecutive cycles
	task t_back_to_back;
		evt_valid = 1'h1;
		evt_kind = `EVT_ALLOC;
		evt_line = 6'h20;
		{evt_partition_id, evt_monitor_group, evt_security_space_flag} =
			{4'h7, 1'h1, 1'h0};
		tick;
		evt_kind = `EVT_EVICT;
		{evt_partition_id, evt_monitor_group, evt_security_space_flag} =
			{4'h2, 1'h0, 1'h1};
		tick;
		evt_valid = 1'h0;
		chk({down_valid_q, dn}, {1'h1, 2'h0, 6'h20, 4'h7, 1'h1, 1'h0});
		tick;
		chk({down_valid_q, dn}, {1'h1, 2'h1, 6'h20, 4'h7, 1'h1, 1'h0});
		$display("test back_to_back done");
	endtask
	// default-labelled requester, then monitor filtering on group too
	task t_group;
		ev(`EVT_ALLOC, 6'h12, 4'h0, 1'h0, 1'h0);
		chk({down_valid_q, dn}, {1'h1, 2'h0, 6'h12, 4'h0, 1'h0, 1'h0});
		{mon_monitor_group, mon_group_match} = 2'h3;
		ev(`EVT_ALLOC, 6'h11, 4'h3, 1'h0, 1'h0);
		chk(mon_event_q, 1'h0);
		ev(`EVT_LOOKUP, 6'h11, 4'h3, 1'h1, 1'h0);
		chk(mon_event_q, 1'h1);
		chk(mon_storage_q, 7'h01);
		$display("test group done");
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// tests need under 100 cycles; 2500 leaves wide margin
	initial begin
		#100000;
		n_fail++;
		give_verdict;
	end
	// reset, then the scenarios in order; each leaves lines it needs
	initial begin
		rst = 1'h1;
		{evt_valid, evt_kind, evt_line, evt_partition_id} = 14'h0000;
		{evt_monitor_group, evt_security_space_flag, cfg_we} = 3'h0;
		{cfg_index, cfg_portion_bitmap, cfg_max_lines} = 16'h0000;
		{mon_partition_id, mon_security_space_flag} = 5'h06;
		{mon_monitor_group, mon_group_match} = 2'h0;
		n_fail = 0;
		n_tests = 0;
		repeat (8) @(posedge clock);
		#1 rst = 1'h0;
		// first event only after the edge that saw reset low
		tick;
		t_fill_evict;
		t_clean_inval;
		t_lookup;
		t_relabel;
		t_back_to_back;
		t_group;
		give_verdict;
	end
endmodule // cache_label_track_bench
`default_nettype wire
